// >>> design/bipm_controller.sv
`timescale 1ns/1ps
module bipm_controller (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Serial external interrupt line
    input wire logic serSync,
    input wire logic serData,
    // On-chip unit requests
    input wire bipm_pkg::bipm_unit_req_t unitReq,
    // Timer and priority setup
    input wire bipm_pkg::bipm_timer_cfg_t timerCfg,
    input wire bipm_pkg::bipm_prio_wr_t prioWr,
    // Core side
    input wire logic intAck,
    output bipm_pkg::bipm_core_req_t coreReq,
    output logic [bipm_pkg::NUM_TIMERS-1:0] timerTick
);
    import bipm_pkg::*;

    bipm_ctrl_st_t st_ff;
    bipm_ctrl_st_t nxt_st;
    logic [EXT_SLOTS-1:0] extLevels;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] tclr;
    logic [4:0] ackIdx;
    bipm_prio_t bestPrio;
    logic [4:0] bestIdx;
    // Checker helper: the table that the shown request was chosen from
    bipm_prio_t [NUM_SRC-1:0] prioPrev_ff;

    // External sources from the time-division line
    bipm_serial_demux demux (
        .mclk(mclk),
        .resetn(resetn),
        .serSync(serSync),
        .serData(serData),
        .extLevels(extLevels)
    );

    // Source vector: external slots, then sticky timer events, then units
    assign pend = {unitReq.msg, unitReq.dma_channel_one_irq, unitReq.dma_channel_zero_irq, unitReq.i2c,
                   st_ff.tpend, extLevels};

    // Source index of the request now shown to the core
    assign ackIdx = 5'(st_ff.req.vector - VEC_BASE);

    always_comb begin
        nxt_st = st_ff;
        tick = '0;
        tclr = '0;
        bestPrio = PRIO_MASKED;
        bestIdx = '0;
        // Tick timers count down while enabled and reload at zero
        for (int t = 0; t < NUM_TIMERS; t++) begin
            if (!timerCfg.enable[t]) begin
                nxt_st.cnt[t] = timerCfg.period[t];
            end else if (st_ff.cnt[t] == '0) begin
                tick[t] = 1'b1;
                nxt_st.cnt[t] = timerCfg.period[t];
            end else begin
                nxt_st.cnt[t] = st_ff.cnt[t] - 1'b1;
            end
            // Ack of a timer vector clears its event
            if (intAck && st_ff.req.valid && ackIdx == 5'(SRC_TICK_TIMER_ZERO + t)) begin
                tclr[t] = 1'b1;
            end
        end
        // A tick in the ack cycle survives the clear
        nxt_st.tpend = (st_ff.tpend & ~tclr) | tick;
        // Priority writes; out of range indexes are dropped
        if (prioWr.write && prioWr.index < 5'(NUM_SRC)) begin
            nxt_st.prio[prioWr.index] = prioWr.value;
        end
        // Strict compare: ties go to the lower source number, and
        // a zero priority never beats the starting value
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pend[i] && st_ff.prio[i] > bestPrio) begin
                bestPrio = st_ff.prio[i];
                bestIdx = 5'(i);
            end
        end
        nxt_st.req.valid = bestPrio != PRIO_MASKED;
        nxt_st.req.vector = VEC_BASE + 8'(bestIdx);
        nxt_st.req.prio = bestPrio;
    end

    // Defaults load on reset, so software starts from the board map
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_ff.prio <= PRIO_RST;
            st_ff.cnt <= '0;
            st_ff.tpend <= '0;
            st_ff.req <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign coreReq = st_ff.req;
    assign timerTick = tick;

    // Request lags the table by one cycle, so a write must not trip the check
    always_ff @(posedge mclk) begin
        prioPrev_ff <= st_ff.prio;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence afterResetS;
        !$past(resetn);
    endsequence

    sequence topWriteS;
        prioWr.write && prioWr.index == 5'(SRC_MSG) && prioWr.value == PRIO_TOP;
    endsequence

    never_masked_a: assert property (coreReq.valid |-> coreReq.prio != PRIO_MASKED)
        else $error("masked priority presented");
    zero_silent_a: assert property ((st_ff.prio == '0) |=> !coreReq.valid)
        else $error("request with all sources masked");
    vector_span_a: assert property (coreReq.valid |->
        coreReq.vector >= VEC_BASE && coreReq.vector <= VEC_LAST)
        else $error("vector out of map");
    vector_prio_a: assert property (coreReq.valid |->
        coreReq.prio == prioPrev_ff[coreReq.vector - VEC_BASE])
        else $error("vector does not match its priority");
    ext_default_a: assert property (afterResetS |->
        st_ff.prio[SRC_UART] == 4'h8 && st_ff.prio[6] == 4'h0 && st_ff.prio[1] == 4'h1)
        else $error("external default priority wrong");
    timer_default_a: assert property (afterResetS |->
        st_ff.prio[SRC_TICK_TIMER_ZERO] == 4'hc && st_ff.prio[SRC_TICK_TIMER_ZERO + 3] == 4'h2)
        else $error("timer default priority wrong");
    unit_default_a: assert property (afterResetS |->
        st_ff.prio[SRC_I2C] == 4'h4 && st_ff.prio[SRC_MSG] == 4'h7)
        else $error("unit default priority wrong");
    prio_write_a: assert property (topWriteS ##1 (unitReq.msg && !prioWr.write) |=>
        coreReq.valid && coreReq.vector == VEC_LAST && coreReq.prio == PRIO_TOP)
        else $error("top priority messaging not presented");
    tick_sticky_a: assert property (tick[0] |=> st_ff.tpend[0])
        else $error("timer event lost");
    tick_period_a: assert property (tick[1] && timerCfg.enable[1] &&
        timerCfg.period[1] == 16'h2 ##1 $stable(timerCfg) [*3] |-> tick[1])
        else $error("timer period wrong");
endmodule

// >>> design/bipm_pkg.sv
package bipm_pkg;
    // Source counts and widths
    localparam int NUM_SRC = 24;
    localparam int EXT_SLOTS = 16;
    localparam int NUM_TIMERS = 4;
    localparam int TIMER_W = 16;
    localparam int SLOT_W = 4;

    // Source numbers of the internal sources and of the UART slot
    localparam int SRC_TICK_TIMER_ZERO = 16;
    localparam int SRC_I2C = 20;
    localparam int SRC_DMA_CHANNEL_ZERO_IRQ = 21;
    localparam int SRC_DMA_CHANNEL_ONE_IRQ = 22;
    localparam int SRC_MSG = 23;
    localparam int SRC_UART = 4;

    // Vector of source n is VEC_BASE plus n, 0x10 up to 0x27
    localparam logic [7:0] VEC_BASE = 8'h10;
    localparam logic [7:0] VEC_LAST = 8'h27;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 4'hf;

    typedef logic [3:0] bipm_prio_t;
    localparam bipm_prio_t PRIO_MASKED = 4'h0;
    localparam bipm_prio_t PRIO_TOP = 4'hf;

    // Priorities after reset, source 23 first, source 0 last
    localparam bipm_prio_t [NUM_SRC-1:0] PRIO_RST = {
        4'h7, 4'h7, 4'h7, 4'h4,
        4'h2, 4'h2, 4'hc, 4'hc,
        4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
        4'h1, 4'h1, 4'h0, 4'h0, 4'h6, 4'h8, 4'h7, 4'h7, 4'h1, 4'h1};

    // Priority programming port
    typedef struct packed {
        logic write;
        logic [4:0] index;
        bipm_prio_t value;
    } bipm_prio_wr_t;

    // Tick timer setup
    typedef struct packed {
        logic [NUM_TIMERS-1:0] enable;
        logic [NUM_TIMERS-1:0][TIMER_W-1:0] period;
    } bipm_timer_cfg_t;

    // On-chip unit requests, levels
    typedef struct packed {
        logic i2c;
        logic dma_channel_zero_irq;
        logic dma_channel_one_irq;
        logic msg;
    } bipm_unit_req_t;

    // Request presented to the core
    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        bipm_prio_t prio;
    } bipm_core_req_t;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        logic [EXT_SLOTS-1:0] shift;
        logic [EXT_SLOTS-1:0] frame;
    } bipm_demux_st_t;

    typedef struct packed {
        bipm_prio_t [NUM_SRC-1:0] prio;
        logic [NUM_TIMERS-1:0][TIMER_W-1:0] cnt;
        logic [NUM_TIMERS-1:0] tpend;
        bipm_core_req_t req;
    } bipm_ctrl_st_t;
endpackage

// >>> design/bipm_serial_demux.sv
`timescale 1ns/1ps
module bipm_serial_demux (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Serial interrupt line
    input wire logic serSync,
    input wire logic serData,
    // Recovered source levels
    output logic [bipm_pkg::EXT_SLOTS-1:0] extLevels
);
    import bipm_pkg::*;

    bipm_demux_st_t st_ff;
    bipm_demux_st_t nxt_st;
    logic [SLOT_W-1:0] slotNow;

    // One slot per clock; sync marks slot 0 and realigns the count
    always_comb begin
        nxt_st = st_ff;
        slotNow = serSync ? '0 : st_ff.slot;
        nxt_st.shift[slotNow] = serData;
        nxt_st.slot = slotNow + 4'h1;
        if (slotNow == SLOT_LAST) begin
            // Whole frame moves at once, so no source sees a half frame
            nxt_st.frame = nxt_st.shift;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign extLevels = st_ff.frame;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence lastSlotS;
        !serSync && st_ff.slot == SLOT_LAST;
    endsequence

    slot_frame_a: assert property (lastSlotS |=> extLevels == $past(nxt_st.shift))
        else $error("frame not taken at last slot");
    sync_align_a: assert property (serSync |=> st_ff.slot == 4'h1)
        else $error("slot count not realigned by sync");
endmodule

// >>> verif/bipm_core_model.sv
`timescale 1ns/1ps
module bipm_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Controller side
    input wire bipm_pkg::bipm_core_req_t coreReq,
    input wire logic ackEn,
    output logic intAck
);
    import bipm_pkg::*;
    // Acks timer vectors only; level sources clear at their origin
    always @(posedge mclk) begin
        intAck <= resetn && ackEn && coreReq.valid && !intAck
            && coreReq.vector >= 8'h20 && coreReq.vector <= 8'h23;
    end
endmodule

// >>> verif/tb_board_interrupt_priority_map.sv
`timescale 1ns/1ps
module tb_board_interrupt_priority_map;
    import bipm_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic serSync = 1'b0;
    logic serData = 1'b0;
    logic ackEn = 1'b0;
    logic intAck;
    bipm_unit_req_t unitReq = '0;
    bipm_timer_cfg_t timerCfg = '0;
    bipm_prio_wr_t prioWr = '0;
    bipm_core_req_t coreReq;
    logic [NUM_TIMERS-1:0] timerTick;
    int errors = 0;
    int cmp_count = 0;
    // Default external priorities, source 0 first
    localparam bipm_prio_t DEF_EXT [16] = '{4'h1, 4'h1, 4'h7, 4'h7, 4'h8, 4'h6,
        4'h0, 4'h0, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

    // Clock
    always #2.5 mclk = ~mclk;

    bipm_controller u_dut (.mclk(mclk), .resetn(resetn), .serSync(serSync),
        .serData(serData), .unitReq(unitReq), .timerCfg(timerCfg), .prioWr(prioWr),
        .intAck(intAck), .coreReq(coreReq), .timerTick(timerTick));
    bipm_core_model u_core (.mclk(mclk), .resetn(resetn), .coreReq(coreReq),
        .ackEn(ackEn), .intAck(intAck));

    task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Vector and priority mean nothing while idle, so only valid is compared then
    task automatic look(input string name, input int n, input logic [12:0] exp);
        repeat (n) @(posedge mclk);
        #1;
        chk(name, exp[12] ? 13'(coreReq) : {coreReq.valid, 12'h0}, exp);
    endtask

    // One frame, slot 0 first, sync on slot 0
    task automatic send_frame(input logic [15:0] lv);
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            serSync <= (i == 0);
            serData <= lv[i];
        end
        @(posedge mclk);
        serSync <= 1'b0;
        serData <= 1'b0;
    endtask

    task automatic set_prio(input int idx, input bipm_prio_t val);
        @(posedge mclk);
        prioWr <= '{1'b1, 5'(idx), val};
        @(posedge mclk);
        prioWr <= '0;
    endtask

    // Each unit alone, then all at once: equal priority goes to the lower number
    task automatic test_units();
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            unitReq <= bipm_unit_req_t'(4'(4'b1000 >> k));
            look("unit", 2, {1'b1, 8'h24 + 8'(k), (k == 0) ? 4'h4 : 4'h7});
        end
        @(posedge mclk);
        unitReq <= 4'hf;
        look("unit_all", 2, {1'b1, 8'h25, 4'h7});
        // Messaging alone, raised to the top and put back
        @(posedge mclk);
        unitReq <= 4'h1;
        set_prio(SRC_MSG, 4'hf);
        look("unit_top", 1, {1'b1, 8'h27, 4'hf});
        set_prio(SRC_MSG, 4'h7);
        @(posedge mclk);
        unitReq <= '0;
    endtask

    // Every slot alone, including the unused ones
    task automatic test_serial();
        for (int n = 0; n < 16; n++) begin
            send_frame(16'h1 << n);
            look("ext", 3, (DEF_EXT[n] != 4'h0) ? {1'b1, 8'h10 + 8'(n), DEF_EXT[n]} : 13'h0);
        end
    endtask

    // Reprogramming reorders and masks pending sources
    task automatic test_prio();
        send_frame(16'h0054);
        look("mix", 3, {1'b1, 8'h14, 4'h8});
        set_prio(6, 4'hf);
        look("raised", 3, {1'b1, 8'h16, 4'hf});
        set_prio(6, 4'h0);
        set_prio(4, 4'h0);
        set_prio(2, 4'h0);
        look("masked", 3, 13'h0);
        send_frame(16'h0);
    endtask

    // Sticky timer events, masked and then acknowledged away
    task automatic test_timers();
        @(posedge mclk);
        timerCfg <= '{enable: 4'hf, period: {4{16'h0010}}};
        look("timer", 20, {1'b1, 8'h20, 4'hc});
        set_prio(16, 4'h0);
        set_prio(17, 4'h0);
        look("tick_timer_two", 3, {1'b1, 8'h22, 4'h2});
        @(posedge mclk);
        timerCfg <= '0;
        ackEn <= 1'b1;
        look("acked", 12, 13'h0);
    endtask

    // Timer one alone with reload 2 ticks every third cycle
    task automatic test_tick();
        @(posedge mclk);
        timerCfg <= '{enable: 4'h2, period: {16'h0, 16'h0, 16'h2, 16'h0}};
        for (int c = 0; c < 7; c++) begin
            #1;
            chk("tick", 13'(timerTick), (c % 3 == 0) ? 13'h2 : 13'h0);
            @(posedge mclk);
        end
        timerCfg <= '0;
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        look("reset", 1, 13'h0);
        test_units();
        test_serial();
        test_prio();
        test_timers();
        test_tick();
        wrap_up();
    end

    // Watchdog, far beyond the few hundred cycles the tests take
    initial begin
        #20000;
        errors++;
        wrap_up();
    end
endmodule
